// [design/sfpp_pkg.sv]
package sfpp_pkg;

   // Clock and timing
   localparam int CLK_MHZ        = 20;
   localparam int PAGE_WRITE_US  = 5400;
   localparam int CHIP_ERASE_MS  = 450;
   localparam int PAGE_WRITE_CYC = PAGE_WRITE_US * CLK_MHZ;
   localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * 1000 * CLK_MHZ;
   localparam int BUSY_W         = 24;

   // Geometry
   localparam int BUF_AW      = 7;
   localparam int PAGE_AW     = 8;
   localparam int FLASH_AW    = 15;
   localparam int PAGE_BYTES  = 128;
   localparam int TIMING_W    = 6;
   localparam int SIG_COUNT   = 6;

   // Instruction codes
   localparam logic [7:0] OP_PREFIX     = 8'hAC;
   localparam logic [7:0] SUB_ENABLE    = 8'h53;
   localparam logic [7:0] SUB_TIMING    = 8'h5D;
   localparam logic [2:0] SUB_ERASE     = 3'h4;
   localparam logic [2:0] SUB_LOCK_WR   = 3'h7;
   localparam logic [3:0] OP_LOAD_HI    = 4'h4;
   localparam logic [3:0] OP_READ_HI    = 4'h2;
   localparam logic [2:0] OP_HL_LOW     = 3'h0;
   localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
   localparam logic [7:0] OP_READ_LOCK  = 8'h58;
   localparam logic [7:0] OP_READ_SIG   = 8'h30;

   // Field positions
   localparam int HL_BIT         = 3;
   localparam int LOCK_READ_BIT  = 0;
   localparam int LOCK_SIZE_LSB  = 1;
   localparam int LOCK_BOOT_BIT  = 4;

   // Values
   localparam logic [7:0] LOCK_RESET     = 8'hFF;
   localparam logic [7:0] ERASED_BYTE    = 8'hFF;
   localparam logic [7:0] READ_BUSY_BYTE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE      = 8'h00;
   localparam logic [5:0] TIMING_RESET   = 6'h0A;

   typedef struct packed {
      logic                wr;
      logic                erase;
      logic [FLASH_AW-1:0] addr;
      logic [7:0]          wdata;
   } sfpp_flash_t;

   typedef enum logic [1:0] {
      SFPP_IDLE = 2'b00,
      SFPP_PROGRAMMING_SELECT_N = 2'b01,
      SFPP_WAIT = 2'b10
   } sfpp_state_t;

endpackage

// [design/sfpp_page_buf.sv]
`timescale 1ns/1ps
module sfpp_page_buf (
   input  wire logic                        clk,
   input  wire logic                        wr_en,
   input  wire logic [sfpp_pkg::BUF_AW-1:0] wr_addr,
   input  wire logic [7:0]                  wr_data,
   input  wire logic [sfpp_pkg::BUF_AW-1:0] rd_addr,
   output logic      [7:0]                  rd_data
);
   import sfpp_pkg::*;

   logic [7:0] mem [0:PAGE_BYTES-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule // sfpp_page_buf

// [design/sfpp_port.sv]
// Functional notes
// - Enable instruction AC 53 comes first
// - Aligned: echo 53 during byte three
// - Misaligned: return zeros during byte three
// - Set timing loads six bits of byte four
// - Chip erase sets flash and locks high
// - Load writes byte four into buffer
// - Buffer holds 128 bytes, 7-bit address
// - Write page programs buffer to page
// - Page write done in 5.4 ms; reads FF
// - Read returns flash byte in byte four
// - Lock write ANDs byte four into locks
// - Locks return high only by erase
// - Lock size protects top of flash
// - Boot lock bit protects page zero
// - Readback disable returns zeros on read
// - Read locks returns lock byte
// - Read signature returns one of six
// - Slave active only while select is low
// - Sample on rising, shift on falling
`timescale 1ns/1ps
module sfpp_port #(
   parameter int unsigned PAGE_WRITE_CYCLES = sfpp_pkg::PAGE_WRITE_CYC,
   parameter int unsigned CHIP_ERASE_CYCLES = sfpp_pkg::CHIP_ERASE_CYC,
   // Arbitrary identification bytes, byte 0 in the low bits
   parameter logic [47:0] SIGNATURE         = 48'h5A_4B_3C_2D_1E_0F
) (
   input  wire logic                          clk,
   input  wire logic                          resetn,
   input  wire logic                          programming_select_n,
   input  wire logic                          sck,
   input  wire logic                          si,
   output logic                               so,
   input  wire logic [7:0]                    flash_rdata,
   output sfpp_pkg::sfpp_flash_t              flash_req,
   output logic [sfpp_pkg::TIMING_W-1:0]      flash_write_timing,
   output logic [7:0]                         flash_lock_byte,
   output logic                               flash_busy,
   output logic                               serial_enabled
);
   import sfpp_pkg::*;

   logic [1:0]          sck_sync;
   logic [1:0]          si_sync;
   logic [1:0]          sel_sync;
   logic                sck_last;
   logic                active;
   logic                rise;
   logic                fall;
   logic [4:0]          bit_cnt;
   logic [31:0]         shift;
   logic [31:0]         next_shift;
   logic                frame_done;
   logic [2:0]          bit_idx;
   logic [7:0]          out_byte;
   logic [1:0]          rd_stage;
   logic [7:0]          b1;
   logic [7:0]          b2;
   logic [7:0]          b3;
   logic [7:0]          b4;
   logic                enable_match;
   logic                is_read;
   logic                cmd_timing;
   logic                cmd_erase;
   logic                cmd_lock_wr;
   logic                cmd_load;
   logic                cmd_write;
   sfpp_state_t         state;
   logic [BUSY_W-1:0]   busy_cnt;
   logic [PAGE_AW-1:0]  page;
   logic [BUF_AW-1:0]   programming_select_n_idx;
   logic                phase;
   logic [BUF_AW-1:0]   buf_raddr;
   logic [7:0]          buf_rdata;
   logic                buf_wr;

   function automatic logic page_locked(input logic [7:0] pg,
                                        input logic [7:0] lock);
      logic [2:0] size;
      logic       top;
      size = lock[LOCK_SIZE_LSB +: 3];
      case (size)
         3'h0:    top = 1'b1;
         3'h7:    top = 1'b0;
         default: top = (pg >= ~(8'hFF >> size));
      endcase
      // Bits 7:5 play no part here
      return top | ((pg == 8'h00) & ~lock[LOCK_BOOT_BIT]);
   endfunction

   function automatic logic [7:0] sig_byte(input logic [2:0] sel);
      if (int'(sel) < SIG_COUNT) begin
         return SIGNATURE[8*sel +: 8];
      end
      return ZERO_BYTE;
   endfunction

   // Pins come from the programmer's domain
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sck_sync <= 2'b00;
         si_sync  <= 2'b00;
         sel_sync <= 2'b11;
         sck_last <= 1'b0;
      end else begin
         sck_sync <= {sck_sync[0], sck};
         si_sync  <= {si_sync[0], si};
         sel_sync <= {sel_sync[0], programming_select_n};
         sck_last <= sck_sync[1];
      end
   end

   assign active = ~sel_sync[1];
   assign rise   = active & sck_sync[1] & ~sck_last;
   assign fall   = active & ~sck_sync[1] & sck_last;

   assign next_shift = {shift[30:0], si_sync[1]};
   assign frame_done = rise & (bit_cnt == 5'd31);
   assign b1         = next_shift[31:24];
   assign b2         = next_shift[23:16];
   assign b3         = next_shift[15:8];
   assign b4         = next_shift[7:0];

   // Bit counter and input shifter, MSB first
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt <= 5'd0;
         shift   <= 32'h0000_0000;
      end else if (!active) begin
         bit_cnt <= 5'd0;
         shift   <= 32'h0000_0000;
      end else if (rise) begin
         bit_cnt <= bit_cnt + 5'd1;
         shift   <= next_shift;
      end
   end

   // An extra pulse from the programmer shifts this boundary
   assign enable_match = (next_shift[15:0] == {OP_PREFIX, SUB_ENABLE});

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         serial_enabled <= 1'b0;
      end else if (!active) begin
         serial_enabled <= 1'b0;
      end else if (rise && bit_cnt == 5'd15 && enable_match) begin
         serial_enabled <= 1'b1;
      end
   end

   // Read-type decode on the bytes seen so far
   always_comb begin
      is_read = 1'b0;
      if (next_shift[23:20] == OP_READ_HI
          && next_shift[18:16] == OP_HL_LOW) begin
         is_read = 1'b1;
      end
      if (next_shift[23:16] == OP_READ_LOCK
          || next_shift[23:16] == OP_READ_SIG) begin
         is_read = 1'b1;
      end
   end

   // Answer byte; the read value arrives a few clocks after byte three,
   // which the programmer's ten-period gap
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_byte <= ZERO_BYTE;
         rd_stage <= 2'd0;
      end else if (!active) begin
         out_byte <= ZERO_BYTE;
         rd_stage <= 2'd0;
      end else if (rise) begin
         rd_stage <= 2'd0;
         case (bit_cnt)
            5'd15: begin
               if (enable_match) begin
                  out_byte <= SUB_ENABLE;
               end else begin
                  out_byte <= ZERO_BYTE;
               end
            end
            5'd23: begin
               out_byte <= ZERO_BYTE;
               if (serial_enabled && is_read) begin
                  rd_stage <= 2'd2;
               end
            end
            default: begin
               out_byte <= out_byte;
               if (bit_cnt[2:0] == 3'd7) begin
                  out_byte <= ZERO_BYTE;
               end
            end
         endcase
      end else if (rd_stage != 2'd0) begin
         rd_stage <= rd_stage - 2'd1;
         if (rd_stage == 2'd1) begin
            if (state != SFPP_IDLE) begin
               out_byte <= READ_BUSY_BYTE;
            end else if (shift[23:16] == OP_READ_LOCK) begin
               out_byte <= flash_lock_byte;
            end else if (shift[23:16] == OP_READ_SIG) begin
               out_byte <= sig_byte(shift[2:0]);
            end else if (flash_lock_byte[LOCK_READ_BIT]) begin
               out_byte <= flash_rdata;
            end else begin
               out_byte <= ZERO_BYTE;
            end
         end
      end
   end

   // Bit of the answer byte that the next falling edge puts out
   assign bit_idx = 3'd7 - bit_cnt[2:0];

   // Pin moves only at a falling edge, so a bit stands a whole period;
   // a byte loaded at a rising edge waits for the next fall
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         so <= 1'b0;
      end else if (!active) begin
         so <= 1'b0;
      end else if (fall) begin
         so <= out_byte[bit_idx];
      end
   end

   // Whole-instruction decode at the last rising edge
   assign cmd_timing  = frame_done && serial_enabled
                        && b1 == OP_PREFIX && b2 == SUB_TIMING;
   assign cmd_erase   = frame_done && serial_enabled
                        && b1 == OP_PREFIX && b2[7:5] == SUB_ERASE;
   assign cmd_lock_wr = frame_done && serial_enabled
                        && b1 == OP_PREFIX && b2[7:5] == SUB_LOCK_WR;
   assign cmd_load    = frame_done && serial_enabled
                        && b1[7:4] == OP_LOAD_HI && b1[2:0] == OP_HL_LOW;
   assign cmd_write   = frame_done && serial_enabled
                        && b1 == OP_WRITE_PAGE;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flash_write_timing <= TIMING_RESET;
      end else if (cmd_timing) begin
         flash_write_timing <= b4[TIMING_W-1:0];
      end
   end

   // Erase is the only way back to ones
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flash_lock_byte <= LOCK_RESET;
      end else if (cmd_erase && state == SFPP_IDLE) begin
         flash_lock_byte <= ERASED_BYTE;
      end else if (cmd_lock_wr) begin
         flash_lock_byte <= flash_lock_byte & b4;
      end
   end

   // Buffer is left alone while a page is being copied out
   assign buf_wr    = cmd_load && state == SFPP_IDLE;
   assign buf_raddr = programming_select_n_idx;

   sfpp_page_buf u_buf (
      .clk     (clk),
      .wr_en   (buf_wr),
      .wr_addr ({b3[7:2], b1[HL_BIT]}),
      .wr_data (b4),
      .rd_addr (buf_raddr),
      .rd_data (buf_rdata)
   );

   // Page write and erase sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state     <= SFPP_IDLE;
         busy_cnt  <= '0;
         page      <= 8'h00;
         programming_select_n_idx  <= '0;
         phase     <= 1'b0;
         flash_req <= '0;
      end else begin
         flash_req.wr    <= 1'b0;
         flash_req.erase <= 1'b0;
         case (state)
            SFPP_IDLE: begin
               if (rise && bit_cnt == 5'd23 && serial_enabled) begin
                  // Only three bytes are in, so they sit one byte low
                  flash_req.addr <= {next_shift[15:8], next_shift[7:2],
                                     next_shift[16 + HL_BIT]};
               end
               if (cmd_erase) begin
                  flash_req.erase <= 1'b1;
                  busy_cnt <= BUSY_W'(CHIP_ERASE_CYCLES - 1);
                  state    <= SFPP_WAIT;
               end else if (cmd_write
                            && !page_locked(b2, flash_lock_byte)) begin
                  page     <= b2;
                  programming_select_n_idx <= '0;
                  phase    <= 1'b0;
                  busy_cnt <= BUSY_W'(PAGE_WRITE_CYCLES - 1);
                  state    <= SFPP_PROGRAMMING_SELECT_N;
               end
            end
            SFPP_PROGRAMMING_SELECT_N: begin
               busy_cnt <= busy_cnt - BUSY_W'(1);
               phase    <= ~phase;
               if (phase) begin
                  flash_req.wr    <= 1'b1;
                  flash_req.addr  <= {page, programming_select_n_idx};
                  flash_req.wdata <= buf_rdata;
                  programming_select_n_idx        <= programming_select_n_idx + BUF_AW'(1);
                  if (programming_select_n_idx == BUF_AW'(PAGE_BYTES - 1)) begin
                     state <= SFPP_WAIT;
                  end
               end
            end
            SFPP_WAIT: begin
               // Counts the rest of the fixed page or erase time
               if (busy_cnt == '0) begin
                  state <= SFPP_IDLE;
               end else begin
                  busy_cnt <= busy_cnt - BUSY_W'(1);
               end
            end
            default: begin
               state <= SFPP_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flash_busy <= 1'b0;
      end else begin
         flash_busy <= (state != SFPP_IDLE);
      end
   end

endmodule // sfpp_port

// [tb/sfpp_programmer.sv]
`timescale 1ns/1ps
module sfpp_programmer (
   output logic      sck,
   output logic      si,
   input  wire logic so
);
   int unsigned half_ns = 200;  // Raise for a slow programmer
   logic [31:0] rx;
   initial begin
      sck = 1'b0;  // Stands low between frames
      si = 1'b1;
      rx = '0;
   end
   // Extra pulse steps the slave's bit count
   task automatic pulse();
      #(half_ns) sck = 1'b1;
      #(half_ns) sck = 1'b0;
   endtask
   // Whole frame, byte one first, MSB first
   task automatic xfer(input logic [31:0] cmd, output logic [7:0] b3,
                       output logic [7:0] b4);
      for (int n = 31; n >= 0; n--) begin
         si = cmd[n];
         if (n == 7)
            #500;  // Over nine clocks before byte four
         #(half_ns) sck = 1'b1;
         #(half_ns) rx = {rx[30:0], so};  // Bit stands until the fall
         sck = 1'b0;
      end
      si = ~si;  // Released line must not pass for data
      b3 = rx[15:8];
      b4 = rx[7:0];
   endtask
endmodule // sfpp_programmer

// [tb/sfpp_port_checker.sv]
`timescale 1ns/1ps
module sfpp_port_checker #(
   parameter int unsigned PAGE_WRITE_CYCLES = sfpp_pkg::PAGE_WRITE_CYC,
   parameter int unsigned CHIP_ERASE_CYCLES = sfpp_pkg::CHIP_ERASE_CYC
) (
   input wire logic                          clk,
   input wire logic                          resetn,
   input wire logic                          programming_select_n,
   input wire logic                          sck,
   input wire logic                          si,
   input wire logic                          so,
   input wire logic [7:0]                    flash_rdata,
   input sfpp_pkg::sfpp_flash_t              flash_req,
   input wire logic [sfpp_pkg::TIMING_W-1:0] flash_write_timing,
   input wire logic [7:0]                    flash_lock_byte,
   input wire logic                          flash_busy,
   input wire logic                          serial_enabled
);
   import sfpp_pkg::*;
   localparam int unsigned LIM = ((PAGE_WRITE_CYCLES > CHIP_ERASE_CYCLES) ?
      PAGE_WRITE_CYCLES : CHIP_ERASE_CYCLES) + 2;
   logic [BUSY_W-1:0] busy_run;
   logic [7:0]        wr_run;
   logic [8:0]        top_bound;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         busy_run <= '0;
      else
         busy_run <= flash_busy ? busy_run + 1'b1 : '0;
   end
   // First pulse comes a clock after busy rises; count until both drop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         wr_run <= '0;
      else if (flash_req.wr)
         wr_run <= wr_run + 1'b1;
      else if (!flash_busy)
         wr_run <= '0;
   end
   always_comb begin
      top_bound = (flash_lock_byte[3:1] == 3'h7) ? 9'd256 :
                  9'd256 - (9'd256 >> flash_lock_byte[3:1]);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_reset_values: assert property ($rose(resetn) |->
      flash_write_timing == TIMING_RESET && flash_lock_byte == LOCK_RESET)
      else $error("values after reset wrong");
   a_lock_rise_erase: assert property (
      (|(flash_lock_byte & ~$past(flash_lock_byte))) |->
      $past(flash_busy) or ##[0:3] flash_busy)
      else $error("lock bit rose without erase");
   a_wr_in_busy: assert property (flash_req.wr |-> ##[0:1] flash_busy)
      else $error("byte write outside busy");
   a_wr_pulse: assert property (flash_req.wr |=> !flash_req.wr)
      else $error("write pulse too long");
   a_erase_busy: assert property (flash_req.erase |->
      ##1 !flash_req.erase ##[0:1] flash_busy)
      else $error("erase pulse or busy wrong");
   a_boot_lock: assert property (
      flash_req.wr && !flash_lock_byte[LOCK_BOOT_BIT] |->
      flash_req.addr[14:7] != 8'h00)
      else $error("write to locked page zero");
   a_top_lock: assert property (
      flash_req.wr |-> {1'b0, flash_req.addr[14:7]} < top_bound)
      else $error("write to locked top page");
   a_busy_bound: assert property (flash_busy |-> busy_run < LIM)
      else $error("busy held too long");
   a_page_count: assert property ($fell(flash_busy) |->
      wr_run == 8'd0 || wr_run == 8'd128)
      else $error("page byte count wrong");
   a_deselect_quiet: assert property (
      programming_select_n [*6] |-> !so && !serial_enabled)
      else $error("active while deselected");
   a_enable_sel: assert property (
      $rose(serial_enabled) |-> !programming_select_n)
      else $error("enabled while deselected");
   c_erase: cover property (flash_req.erase);
   c_last_byte: cover property (flash_req.wr && flash_req.addr[6:0] == 7'h7F);
   c_enable: cover property ($rose(serial_enabled));
endmodule // sfpp_port_checker
bind sfpp_port sfpp_port_checker #(
   .PAGE_WRITE_CYCLES(PAGE_WRITE_CYCLES),
   .CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES)
) i_chk (
   .clk(clk), .resetn(resetn), .programming_select_n(programming_select_n),
   .sck(sck), .si(si), .so(so), .flash_rdata(flash_rdata),
   .flash_req(flash_req), .flash_write_timing(flash_write_timing),
   .flash_lock_byte(flash_lock_byte), .flash_busy(flash_busy),
   .serial_enabled(serial_enabled)
);

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import sfpp_pkg::*;
   localparam int unsigned PW = 400;
   localparam int unsigned CE = 100;
   localparam logic [47:0] SIG = 48'h66_55_44_33_22_11;  // Arbitrary
   logic        clk, resetn, programming_select_n, sck, si, so;
   logic        flash_busy, serial_enabled;
   logic [7:0]  flash_rdata, flash_lock_byte, b3, b4;
   logic [5:0]  flash_write_timing;
   sfpp_flash_t flash_req;
   logic [7:0]  mem [0:32767];
   int          errors = 0, check_count = 0, wr_count = 0, cycles = 0;
   sfpp_programmer i_programming_select_n (.sck(sck), .si(si), .so(so));
   sfpp_port #(.PAGE_WRITE_CYCLES(PW), .CHIP_ERASE_CYCLES(CE),
      .SIGNATURE(SIG)) i_dut (
      .clk(clk), .resetn(resetn), .programming_select_n(programming_select_n),
      .sck(sck), .si(si), .so(so), .flash_rdata(flash_rdata),
      .flash_req(flash_req), .flash_write_timing(flash_write_timing),
      .flash_lock_byte(flash_lock_byte), .flash_busy(flash_busy),
      .serial_enabled(serial_enabled));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial foreach (mem[i]) mem[i] = 8'h00;
   // Flash array, one clock read latency; also the run's time limit
   always @(posedge clk) begin
      cycles <= cycles + 1;
      flash_rdata <= mem[flash_req.addr];
      if (flash_req.wr) begin
         mem[flash_req.addr] <= flash_req.wdata;
         wr_count <= wr_count + 1;
      end
      if (flash_req.erase)
         foreach (mem[i]) mem[i] <= 8'hFF;
      if (cycles == 60000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic send(input logic [31:0] cmd);
      @(posedge clk);
      #1 i_programming_select_n.xfer(cmd, b3, b4);
      repeat (4) @(posedge clk);
   endtask
   task automatic nudge();
      @(posedge clk);
      #1 i_programming_select_n.pulse();  // Pin edges kept off the clock edge
   endtask
   task automatic wait_idle();
      repeat (3) @(posedge clk);
      for (int n = 0; n < 2000 && flash_busy !== 1'b0; n++) @(posedge clk);
   endtask
   task automatic rd(input logic [14:0] a);
      send({4'h2, a[0], 3'h0, a[14:7], a[6:1], 2'b00, 8'h00});
   endtask
   task automatic erase();
      send({OP_PREFIX, 8'h80, 16'h0000});
      wait_idle();  // No new frame until the erase is over
   endtask
   task automatic wr_page(input logic [7:0] p, input int exp);
      int start;
      start = wr_count;
      send({OP_WRITE_PAGE, p, 16'h0000});
      wait_idle();
      check("page pulses", 8'(wr_count - start), 8'(exp));
   endtask
   task automatic t_reset();
      check("timing", 8'(flash_write_timing), 8'h0A);
      check("lock", flash_lock_byte, LOCK_RESET);
      check("enabled", 8'(serial_enabled), 8'h00);
   endtask
   task automatic t_enable();
      int n;
      nudge();  // Knock the slave off its byte step
      send({OP_PREFIX, SUB_ENABLE, 16'h0000});
      check("misaligned echo", b3, 8'h00);
      for (n = 1; n < 32 && b3 !== SUB_ENABLE; n++) begin
         nudge();
         send({OP_PREFIX, SUB_ENABLE, 16'h0000});
      end
      check("echo", b3, SUB_ENABLE);
      check("enabled", 8'(serial_enabled), 8'h01);
   endtask
   task automatic t_timing();
      // 20 MHz over 0.8 MHz is 25; top bits must be dropped
      send({OP_PREFIX, SUB_TIMING, 8'h00, 8'hD9});
      check("timing", 8'(flash_write_timing), 8'h19);
   endtask
   task automatic t_page();
      logic [6:0] adr [3] = '{7'h00, 7'h01, 7'h7F};
      logic [7:0] dat [3] = '{8'hA5, 8'h3C, 8'h96};
      int start;
      erase();
      rd(15'h0123);
      check("erased byte", b4, ERASED_BYTE);
      check("erased lock", flash_lock_byte, 8'hFF);
      for (int i = 0; i < 3; i++)
         send({4'h4, adr[i][0], 3'h0, 8'h00, adr[i][6:1], 2'b00, dat[i]});
      start = wr_count;
      send({OP_WRITE_PAGE, 8'h05, 16'h0000});
      check("busy", 8'(flash_busy), 8'h01);
      rd(15'h0280);
      check("busy read", b4, READ_BUSY_BYTE);
      wait_idle();
      check("page pulses", 8'(wr_count - start), 8'd128);
      for (int i = 0; i < 3; i++) begin
         rd({8'h05, adr[i]});
         check("read back", b4, dat[i]);
      end
   endtask
   task automatic t_lock();
      logic [8:0] bnd;
      for (int c = 0; c < 8; c++) begin
         bnd = (c == 7) ? 9'd256 : 9'd256 - (9'd256 >> c);
         erase();
         send({OP_PREFIX, 8'hE0, 8'h00, 4'h1, c[2:0], 1'b1});
         check("lock size", flash_lock_byte, {4'h1, c[2:0], 1'b1});
         if (c > 0)
            wr_page(8'(bnd - 9'd1), 128);
         if (c < 7)
            wr_page(bnd[7:0], 0);
      end
      erase();
      send({OP_PREFIX, 8'hE0, 8'h00, 8'h0F});
      wr_page(8'h00, 0);
      wr_page(8'h01, 128);
      send({OP_PREFIX, 8'hE0, 8'h00, 8'h1E});
      send({OP_PREFIX, 8'hE0, 8'h00, 8'hFF});
      check("lock and", flash_lock_byte, 8'h0E);
      rd(15'h0080);
      check("read off", b4, 8'h00);
      send({OP_READ_LOCK, 24'h000000});
      check("lock read", b4, 8'h0E);
   endtask
   task automatic t_sig();
      for (int s = 0; s < 8; s++) begin
         send({OP_READ_SIG, 8'h00, 5'h00, s[2:0], 8'h00});
         check("signature", b4, (s < 6) ? SIG[8*s +: 8] : 8'h00);
      end
   endtask
   task automatic t_deselect();
      @(posedge clk) #1 programming_select_n = 1'b1;
      repeat (8) @(posedge clk);
      check("deselected", 8'(serial_enabled), 8'h00);
      check("so idle", 8'(so), 8'h00);
      #1 programming_select_n = 1'b0;
      repeat (4) @(posedge clk);
      send({OP_PREFIX, SUB_ENABLE, 16'h0000});
      check("echo again", b3, SUB_ENABLE);
   endtask
   initial begin
      resetn = 1'b0;
      programming_select_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_enable();
      t_timing();
      t_page();
      t_lock();
      t_sig();
      t_deselect();
      give_verdict();
   end
endmodule // testbench
